// ==== hdl/adcocb_output_config_bits.sv ====
// AHB-Lite register bank driving the converter output configuration controls
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "adcocb_consts.svh"
module adcocb_output_config_bits
    import adcocb_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output adcocb_ctrl_t ctrl
);
    adcocb_state_t state;
    adcocb_state_t next_state;

    // Address-phase qualifiers
    logic addrTake;
    logic readTake;

    // Data-phase write strobe, shared by every stored word
    logic writeLand;

    // Register contents as they stand after this cycle's write
    logic [15:0] landedMain;
    logic [15:0] landedRsvd;
    logic [15:0] landedExt;
    adcocb_ctrl_t landedCtrl;

    // ==========================================================
    // Mode decode
    // Unlisted pairs of code and clock bit report the illegal mode, so that
    // software sees a bad setting on the status word instead of a guess
    function automatic adcocb_mode_t decodeMode(input logic [2:0] code,
                                                input logic extClk);
        adcocb_mode_t mode;
        mode = ADCOCB_MODE_ILLEGAL;
        if (extClk) begin
            if (code == `ADCOCB_IM_NORMAL) begin
                mode = ADCOCB_MODE_CLOCK;
            end
        end else begin
            unique case (code)
                `ADCOCB_IM_NORMAL: begin
                    mode = ADCOCB_MODE_NORMAL;
                end
                `ADCOCB_IM_IONLY: begin
                    mode = ADCOCB_MODE_I_ONLY;
                end
                `ADCOCB_IM_QONLY: begin
                    mode = ADCOCB_MODE_Q_ONLY;
                end
                `ADCOCB_IM_BOTH: begin
                    mode = ADCOCB_MODE_BOTH;
                end
                default: begin
                    mode = ADCOCB_MODE_ILLEGAL;
                end
            endcase
        end
        decodeMode = mode;
    endfunction : decodeMode

    // ==========================================================
    // Control word
    // Bit 6 is always exported; the sampler only uses it in dual-edge mode
    function automatic adcocb_ctrl_t buildCtrl(input logic [15:0] mainCfg,
                                               input logic [15:0] extCfg);
        adcocb_ctrl_t c;
        c = '0;
        c.dualEdgeInputSelect = mainCfg[`ADCOCB_BIT_INSEL];
        c.interleaveMode = decodeMode(mainCfg[`ADCOCB_MSB_IMODE:`ADCOCB_LSB_IMODE],
                                      extCfg[`ADCOCB_BIT_EXTCLK]);
        c.twosComplementSelect = mainCfg[`ADCOCB_BIT_FMT];
        c.timestampEnable = mainCfg[`ADCOCB_BIT_TSTAMP];
        c.singleRateOutput = mainCfg[`ADCOCB_BIT_SRATE];
        buildCtrl = c;
    endfunction : buildCtrl

    // ==========================================================
    // Read decode
    // Only the low half of each word is significant; the upper half reads 0
    function automatic logic [31:0] readWord(input logic [7:0] addr,
                                             input logic [15:0] mainCfg,
                                             input logic [15:0] rsvdCfg,
                                             input logic [15:0] extCfg,
                                             input adcocb_ctrl_t ctrlNow);
        logic [31:0] word;
        word = 32'h0000_0000;
        unique case (addr)
            `ADCOCB_ADDR_MAIN: begin
                word = {16'h0000, mainCfg};
            end
            `ADCOCB_ADDR_RSVD: begin
                word = {16'h0000, rsvdCfg};
            end
            `ADCOCB_ADDR_EXT: begin
                word = {16'h0000, extCfg};
            end
            `ADCOCB_ADDR_STATUS: begin
                word = {24'h00_0000, 1'h0, ctrlNow};
            end
            default: begin
                word = 32'h0000_0000;
            end
        endcase
        readWord = word;
    endfunction : readWord

    // ==========================================================
    // Bus qualifiers
    // The slave never inserts wait states, so hready only gates the address phase
    assign addrTake = hsel && hready && htrans == `ADCOCB_HTRANS_NONSEQ;
    assign readTake = addrTake && !hwrite;
    assign writeLand = state.dataPhase && state.dataWrite;

    // ==========================================================
    // Write landing
    // Unmapped addresses and the status word leave every stored word alone
    adcocb_word_land #(
        .WORD_ADDR(`ADCOCB_ADDR_MAIN)
    ) i_landMain (
        .writeLand(writeLand),
        .dataAddr(state.dataAddr),
        .writeData(hwdata[15:0]),
        .heldWord(state.mainConfig),
        .landedWord(landedMain)
    );

    adcocb_word_land #(
        .WORD_ADDR(`ADCOCB_ADDR_RSVD)
    ) i_landRsvd (
        .writeLand(writeLand),
        .dataAddr(state.dataAddr),
        .writeData(hwdata[15:0]),
        .heldWord(state.reservedFixed),
        .landedWord(landedRsvd)
    );

    adcocb_word_land #(
        .WORD_ADDR(`ADCOCB_ADDR_EXT)
    ) i_landExt (
        .writeLand(writeLand),
        .dataAddr(state.dataAddr),
        .writeData(hwdata[15:0]),
        .heldWord(state.extConfig),
        .landedWord(landedExt)
    );
    assign landedCtrl = buildCtrl(landedMain, landedExt);

    // ==========================================================
    // Next state
    always_comb begin
        next_state = state;
        next_state.dataPhase = addrTake;
        if (addrTake) begin
            next_state.dataWrite = hwrite;
            next_state.dataAddr = haddr;
        end
        next_state.mainConfig = landedMain;
        next_state.reservedFixed = landedRsvd;
        next_state.extConfig = landedExt;
        // A read right behind a write to the same word returns the new value
        next_state.readData = 32'h0000_0000;
        if (readTake) begin
            next_state.readData = readWord(haddr, landedMain, landedRsvd, landedExt,
                                           landedCtrl);
        end
        next_state.ctrl = landedCtrl;
    end

    // ==========================================================
    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            state <= '0;
            state.mainConfig <= `ADCOCB_POR_MAIN;
            state.reservedFixed <= `ADCOCB_POR_RSVD;
            state.extConfig <= `ADCOCB_POR_EXT;
            state.ctrl.interleaveMode <= ADCOCB_MODE_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Outputs
    // Zero wait states and an always-OKAY response need no flop
    assign hreadyout = 1'h1;
    assign hresp = 1'h0;
    assign hrdata = state.readData;
    assign ctrl = state.ctrl;
endmodule : adcocb_output_config_bits

// ==========================================================
// Write landing for one stored word
module adcocb_word_land
    import adcocb_pkg::*;
#(
    parameter logic [7:0] WORD_ADDR = 8'h00
)
(
    input wire logic writeLand,
    input wire logic [7:0] dataAddr,
    input wire logic [15:0] writeData,
    input wire logic [15:0] heldWord,
    output logic [15:0] landedWord
);
    // The word moves only in the data phase of a write to its own address
    always_comb begin
        landedWord = heldWord;
        if (writeLand && dataAddr == WORD_ADDR) begin
            landedWord = writeData;
        end
    end
endmodule : adcocb_word_land
`default_nettype wire

// ==== hdl/adcocb_consts.svh ====
// Constants for the output configuration register bank
// ==========================================================
// Operation
// - In dual-edge mode, bit 6 low samples I input, high samples Q input.
// - Interleave mode decodes from bits 7:5 plus the extended clock bit.
// - Bit 4 low gives offset binary output, high gives two's complement.
// - Bit 3 low disables time-stamp capture, high enables it.
// - Bit 2 low clocks output at double rate, high at single rate.
`ifndef ADCOCB_CONSTS_SVH
`define ADCOCB_CONSTS_SVH
`define ADCOCB_IDX_MAIN 4'h0
`define ADCOCB_IDX_RSVD 4'h1
`define ADCOCB_IDX_EXT 4'hE
`define ADCOCB_ADDR_MAIN 8'h00
`define ADCOCB_ADDR_RSVD 8'h04
`define ADCOCB_ADDR_EXT 8'h38
`define ADCOCB_ADDR_STATUS 8'h3C
`define ADCOCB_POR_MAIN 16'h2000
`define ADCOCB_POR_RSVD 16'h2907
`define ADCOCB_POR_EXT 16'h0000
`define ADCOCB_BIT_INSEL 6
`define ADCOCB_BIT_DES 7
`define ADCOCB_BIT_FMT 4
`define ADCOCB_BIT_TSTAMP 3
`define ADCOCB_BIT_SRATE 2
`define ADCOCB_BIT_EXTCLK 6
`define ADCOCB_MSB_IMODE 7
`define ADCOCB_LSB_IMODE 5
`define ADCOCB_IM_NORMAL 3'h0
`define ADCOCB_IM_IONLY 3'h4
`define ADCOCB_IM_QONLY 3'h6
`define ADCOCB_IM_BOTH 3'h5
`define ADCOCB_HTRANS_NONSEQ 2'h2
`define ADCOCB_HSIZE_WORD 3'h2
`endif

// ==== hdl/adcocb_pkg.sv ====
// Types for the output configuration register bank
package adcocb_pkg;
    typedef enum logic [2:0] {
        ADCOCB_MODE_NORMAL = 3'h0,
        ADCOCB_MODE_I_ONLY = 3'h1,
        ADCOCB_MODE_Q_ONLY = 3'h2,
        ADCOCB_MODE_BOTH = 3'h3,
        ADCOCB_MODE_CLOCK = 3'h4,
        ADCOCB_MODE_ILLEGAL = 3'h7
    } adcocb_mode_t;

    typedef struct packed {
        logic dualEdgeInputSelect;
        adcocb_mode_t interleaveMode;
        logic twosComplementSelect;
        logic timestampEnable;
        logic singleRateOutput;
    } adcocb_ctrl_t;

    typedef struct packed {
        logic [15:0] mainConfig;
        logic [15:0] reservedFixed;
        logic [15:0] extConfig;
        logic dataPhase;
        logic dataWrite;
        logic [7:0] dataAddr;
        logic [31:0] readData;
        adcocb_ctrl_t ctrl;
    } adcocb_state_t;
endpackage : adcocb_pkg

// ==== verif/adcocb_monitor.sv ====
// Assertion checker of the output configuration register bank
`timescale 1ns/1ns
`default_nettype none
module adcocb_monitor
    import adcocb_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire adcocb_ctrl_t ctrl
);
    logic pm, pe, eb;
    wire logic go = hsel && hready && htrans == 2'h2 && hwrite && !rst;
    // Mirror of the extended clock bit, needed to know which mode a main write selects
    always_ff @(posedge clock) begin
        pm <= go && haddr == 8'h00;
        pe <= go && haddr == 8'h38;
        eb <= rst ? 1'h0 : (pe ? hwdata[6] : eb);
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence wr_ionly; pm && !eb && hwdata[7:5] == 3'h4; endsequence
    sequence wr_both; pm && !eb && hwdata[7:5] == 3'h5; endsequence
    sequence wr_clock; pm && eb && hwdata[7:5] == 3'h0; endsequence
    a_input_sel: assert property (pm |=> ctrl[6] == $past(hwdata[6]))
        else $error("input select wrong");
    a_mode_ionly: assert property (wr_ionly |=> ctrl[5:3] == ADCOCB_MODE_I_ONLY)
        else $error("interleave mode wrong");
    a_mode_both: assert property (wr_both |=> ctrl[5:3] == ADCOCB_MODE_BOTH)
        else $error("both-input mode wrong");
    a_mode_clock: assert property (wr_clock |=> ctrl[5:3] == ADCOCB_MODE_CLOCK)
        else $error("clock-driven mode wrong");
    a_ctrl_hold: assert property (!pm && !pe |=> $stable(ctrl))
        else $error("controls moved without a write");
    a_out_bits: assert property (pm |=> ctrl[2:0] == $past(hwdata[4:2]))
        else $error("output control bits wrong");
    a_reset_ctrl: assert property (disable iff (1'h0) rst |=> ctrl == 7'h00)
        else $error("reset value wrong");
endmodule : adcocb_monitor
bind adcocb_output_config_bits adcocb_monitor i_mon(.clock(clock), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .ctrl(ctrl));
`default_nettype wire

// ==== verif/tb.sv ====
// Bench for the output configuration register bank
`timescale 1ns/1ns
`default_nettype none
`include "adcocb_consts.svh"
module tb
    import adcocb_pkg::*;
;
    logic clock = '0, rst = '1, hsel = '0, hwrite = '0, hready, hresp;
    logic [7:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic [31:0] hwdata = '0, hrdata, r;
    adcocb_ctrl_t ctrl;
    int error_cnt = 0, comparisons = 0;
    // Main bits 7:5, extended clock bit, expected mode
    logic [6:0] code[7] = '{7'h00, 7'h41, 7'h62, 7'h53, 7'h0C, 7'h17, 7'h4F};
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
    always #4 clock = ~clock;
    adcocb_output_config_bits i_dut(.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(`ADCOCB_HSIZE_WORD), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .ctrl(ctrl));
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        {hsel, haddr, htrans, hwrite} <= {1'h1, a, 2'h2, w};
        do begin @(posedge clock); n++; end while (hready !== 1'h1 && n < 99);
        {htrans, hwdata} <= {2'h0, d};
        do begin @(posedge clock); n++; end while (hready !== 1'h1 && n < 99);
        r = hrdata;
        `CHK("hresp", 1'h0, hresp)
        if (n >= 99) begin error_cnt++; give_verdict(); end
    endtask : xfer
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'h0;
        `CHK("ctrl", 7'h00, ctrl)
        xfer(`ADCOCB_ADDR_MAIN, 1'h0, 32'h0);
        `CHK("main", 32'h2000, r)
        xfer(`ADCOCB_ADDR_RSVD, 1'h1, 32'h2907);
        xfer(`ADCOCB_ADDR_RSVD, 1'h0, 32'h0);
        `CHK("rsvd", 32'h2907, r)
        for (int i = 0; i < 7; i++) begin
            xfer(`ADCOCB_ADDR_EXT, 1'h1, {25'h0, code[i][3], 6'h0});
            xfer(`ADCOCB_ADDR_MAIN, 1'h1, {24'h20, code[i][6:4], i[2:0] ^ 3'h5, 2'h0});
            xfer(`ADCOCB_ADDR_MAIN, 1'h0, 32'h0);
            `CHK("main", {24'h20, code[i][6:4], i[2:0] ^ 3'h5, 2'h0}, r)
            `CHK("ctrl", {code[i][5], code[i][2:0], i[2:0] ^ 3'h5}, ctrl)
            xfer(`ADCOCB_ADDR_STATUS, 1'h0, 32'h0);
            `CHK("status", {25'h0, code[i][5], code[i][2:0], i[2:0] ^ 3'h5}, r)
        end
        xfer(8'h20, 1'h1, 32'hFFFF);
        xfer(8'h20, 1'h0, 32'h0);
        `CHK("unmapped", 32'h0, r)
        rst <= 1'h1;
        repeat (3) @(posedge clock);
        rst <= 1'h0;
        `CHK("ctrl", 7'h00, ctrl)
        xfer(`ADCOCB_ADDR_EXT, 1'h0, 32'h0);
        `CHK("ext", 32'h0, r)
        xfer(`ADCOCB_ADDR_MAIN, 1'h0, 32'h0);
        `CHK("main", 32'h2000, r)
        give_verdict();
    end
endmodule : tb
`default_nettype wire
